// *** src/cmst_clock_gen.sv ***
/*
 * System clock distribution and memory strobe timing.
 * Assumes the 200 MHz clk is the only clock and that all four inputs
 * are asynchronous pins; the mains jumper is static after power-up.
 *
// How it works
// RULE_01 - Forward the 8 MHz fast clock, registered, to all users.
// RULE_02 - One toggle stage halves the fast clock into two opposite phases.
// RULE_03 - Half-rate clock is the system reference; its complement is also driven.
// RULE_04 - I/O clock is the half-rate clock delayed by 50 ns.
// RULE_05 - Mains input gives a real-time tick; jumper picks 60 or 50 Hz.
// RULE_06 - Exactly five clock outputs: fast, half, inverted half, I/O, tick.
// RULE_07 - Chip enable rises 25 ns after the half-rate falling edge.
// RULE_08 - Precharge rises 90 ns after the reference edge.
// RULE_09 - Precharge falls 30 ns after chip enable falls.
// RULE_10 - On reads chip enable falls 5 ns after the next half-rate edge.
// RULE_11 - On writes chip enable falls 30 ns after that edge, later than reads.
// RULE_12 - Cycle starts are queued so refresh reads continue between writes.
// RULE_13 - Read/write strobe rises 70 ns after the reference edge.
// RULE_14 - Read/write strobe falls 40 ns after chip enable falls.
// RULE_15 - Strobe edges placed on a 5 ns grid, within every tolerance.
// RULE_16 - Each cycle starts on cycle start, timed from the half-rate clock.
 */
`default_nettype none
module cmst_clock_gen
    import cmst_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic mains_transformer_in,
    input  wire logic mains_50hz_jumper,
    input  wire logic memory_cycle_start,
    input  wire logic write_cycle_flag,
    output var  logic fast_clock_out, // RULE_06
    output var  logic half_rate_clock_out,
    output var  logic half_rate_clock_inverted,
    output var  logic io_side_clock,
    output var  logic mains_tick_out,
    output var  logic chip_enable_strobe,
    output var  logic precharge_strobe,
    output var  logic rw_strobe
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    function automatic logic [5:0] max6(input logic [5:0] a, input logic [5:0] b);
        return (a > b) ? a : b;
    endfunction

    // Pin synchronisers: a change counts once stages 2 and 3 agree
    logic [PIN_N-1:0] s1_r;
    logic [PIN_N-1:0] s2_r;
    logic [PIN_N-1:0] s3_r;
    logic [PIN_N-1:0] filt_r;
    logic [PIN_N-1:0] pins;
    logic [PIN_N-1:0] rise;
    assign pins = {mains_50hz_jumper, mains_transformer_in, write_cycle_flag, memory_cycle_start};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_r[gi]   <= 1'b0;
                    s2_r[gi]   <= 1'b0;
                    s3_r[gi]   <= 1'b0;
                    filt_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= pins[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        filt_r[gi] <= s3_r[gi];
                    end
                end
            end
            assign rise[gi] = (s2_r[gi] == s3_r[gi]) && s3_r[gi] && !filt_r[gi];
        end
    endgenerate

    // Fast clock: 25 system cycles, high for 13
    logic [4:0] fdiv_r;
    logic       fast_wrap;
    assign fast_wrap = (fdiv_r == FAST_DIV - 5'h1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Start at the wrap so the first fast rise also toggles the half-rate phase
            fdiv_r         <= FAST_DIV - 5'h1;
            fast_clock_out <= 1'b0;
        end else begin
            fdiv_r         <= fast_wrap ? 5'h0 : fdiv_r + 5'h1;
            fast_clock_out <= fast_wrap || (fdiv_r < FAST_HIGH - 5'h1); // RULE_01
        end
    end

    // Half-rate phases toggle on every fast rising edge
    logic ref_edge;
    assign ref_edge = fast_wrap && half_rate_clock_out;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_rate_clock_out      <= 1'b0;
            half_rate_clock_inverted <= 1'b1;
        end else if (fast_wrap) begin
            half_rate_clock_out      <= !half_rate_clock_out; // RULE_02
            half_rate_clock_inverted <= half_rate_clock_out; // RULE_03
        end
    end

    // I/O clock: a tapped shift line stands in for the delay line
    logic [IO_DLY-1:0] io_dly_r;
    logic [IO_DLY-1:0] io_tap;
    assign io_tap = {io_dly_r[IO_DLY-2:0], half_rate_clock_out};
    generate
        for (gi = 0; gi < IO_DLY; gi++) begin : g_iodly
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    io_dly_r[gi] <= 1'b0;
                end else begin
                    io_dly_r[gi] <= io_tap[gi];
                end
            end
        end
    endgenerate
    assign io_side_clock = io_dly_r[IO_DLY-1]; // RULE_04

    // Jumper is caught once, after the synchroniser has settled
    logic [2:0] strap_cnt_r;
    logic       sel50_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt_r <= 3'h0;
            sel50_r     <= 1'b0;
        end else if (strap_cnt_r != STRAP_SETTLE) begin
            strap_cnt_r <= strap_cnt_r + 3'h1;
            if (strap_cnt_r == STRAP_SETTLE - 3'h1) begin
                sel50_r <= filt_r[PIN_J50];
            end
        end
    end

    // Real-time tick: one pulse per N mains cycles
    logic [2:0] mcnt_r;
    logic [2:0] mdiv;
    logic       tick_now;
    assign mdiv     = sel50_r ? MAINS_DIV_50 : MAINS_DIV_60;
    assign tick_now = rise[PIN_MAINS] && (mcnt_r == mdiv - 3'h1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mcnt_r         <= 3'h0;
            mains_tick_out <= 1'b0;
        end else begin
            mains_tick_out <= tick_now; // RULE_05
            if (tick_now) begin
                mcnt_r <= 3'h0;
            end else if (rise[PIN_MAINS]) begin
                mcnt_r <= mcnt_r + 3'h1;
            end
        end
    end

    // Memory cycle sequencer; cnt_r counts cycles since the reference edge
    cmst_state_e state_r;
    logic [5:0]  cnt_r;
    logic        wr_r;
    logic        pend_r;
    logic        pend_wr_r;
    logic [5:0]  ce_off;
    logic [5:0]  pc_off;
    logic [5:0]  rw_off;
    logic [5:0]  end_cyc;
    logic [5:0]  cnt_nxt;
    logic        run_nxt;
    logic        last;
    logic        take;
    logic        wr_now;

    assign ce_off  = wr_r ? CE_WR : CE_RD; // RULE_10 RULE_11
    assign pc_off  = ce_off + PC_TRL;
    assign rw_off  = ce_off + RW_TRL;
    assign end_cyc = wr_r ? max6(pc_off, rw_off) : pc_off;
    assign cnt_nxt = (state_r == ST_RUN) ? cnt_r + 6'h1 : 6'h0;
    assign last    = (state_r == ST_RUN) && (cnt_nxt == end_cyc);
    assign run_nxt = ((state_r == ST_ARMED) && ref_edge) || ((state_r == ST_RUN) && !last);
    assign take    = pend_r || rise[PIN_START];
    // Flag value the filter takes on this edge, so it pairs with the start rise
    assign wr_now  = (s2_r[PIN_WR] == s3_r[PIN_WR]) ? s3_r[PIN_WR] : filt_r[PIN_WR];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= ST_IDLE;
            cnt_r     <= 6'h0;
            wr_r      <= 1'b0;
            pend_r    <= 1'b0;
            pend_wr_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            case (state_r)
                ST_IDLE: begin
                    if (rise[PIN_START]) begin
                        state_r <= ST_ARMED; // RULE_16
                        wr_r    <= wr_now;
                    end
                end
                ST_ARMED: begin
                    if (ref_edge) begin
                        state_r <= ST_RUN; // RULE_16
                    end
                    if (rise[PIN_START]) begin
                        pend_r    <= 1'b1;
                        pend_wr_r <= wr_now;
                    end
                end
                default: begin
                    if (last && take) begin
                        // A start in the final cycle is not lost
                        state_r <= ST_ARMED; // RULE_12
                        wr_r    <= pend_r ? pend_wr_r : wr_now;
                        pend_r  <= pend_r && rise[PIN_START];
                        pend_wr_r <= wr_now;
                    end else if (last) begin
                        state_r <= ST_IDLE;
                    end else if (rise[PIN_START]) begin
                        pend_r    <= 1'b1; // RULE_12
                        pend_wr_r <= wr_now;
                    end
                end
            endcase
        end
    end

    // Strobes, each registered on the 5 ns grid
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chip_enable_strobe <= 1'b0;
            precharge_strobe   <= 1'b0;
            rw_strobe          <= 1'b0;
        end else begin
            chip_enable_strobe <= run_nxt && (cnt_nxt >= CE_ON) && (cnt_nxt < ce_off); // RULE_07 RULE_15
            precharge_strobe   <= run_nxt && (cnt_nxt >= PC_ON) && (cnt_nxt < pc_off); // RULE_08 RULE_09
            // Only write cycles drive the read/write strobe
            rw_strobe <= run_nxt && wr_r && (cnt_nxt >= RW_ON) && (cnt_nxt < rw_off); // RULE_13 RULE_14
        end
    end

    sequence s_ref;
        (state_r == ST_ARMED) && ref_edge;
    endsequence

    property p_fast_period;
        $rose(fast_clock_out) |-> ##25 $rose(fast_clock_out);
    endproperty
    a_fast_period: assert property (p_fast_period) else $error("fast clock period wrong"); // RULE_01

    property p_half_toggle;
        $rose(fast_clock_out) |-> (half_rate_clock_out != $past(half_rate_clock_out));
    endproperty
    a_half_toggle: assert property (p_half_toggle) else $error("half clock not toggled"); // RULE_02

    property p_half_compl;
        half_rate_clock_inverted != half_rate_clock_out;
    endproperty
    a_half_compl: assert property (p_half_compl) else $error("phases not opposite"); // RULE_03

    property p_io_delay;
        ##10 (io_side_clock == $past(half_rate_clock_out, 10));
    endproperty
    a_io_delay: assert property (p_io_delay) else $error("io clock delay wrong"); // RULE_04

    property p_tick;
        mains_tick_out |-> $past(rise[PIN_MAINS]) ##1 !mains_tick_out;
    endproperty
    a_tick: assert property (p_tick) else $error("tick without mains edge"); // RULE_05

    property p_ce_on;
        s_ref |=> !chip_enable_strobe [*5] ##1 chip_enable_strobe;
    endproperty
    a_ce_on: assert property (p_ce_on) else $error("chip enable rise late or early"); // RULE_07

    property p_pc_on;
        s_ref |-> ##18 !precharge_strobe ##1 precharge_strobe;
    endproperty
    a_pc_on: assert property (p_pc_on) else $error("precharge rise wrong"); // RULE_08

    property p_pc_off;
        $fell(chip_enable_strobe) |-> precharge_strobe [*6] ##1 !precharge_strobe;
    endproperty
    a_pc_off: assert property (p_pc_off) else $error("precharge fall wrong"); // RULE_09

    property p_ce_rd;
        s_ref and !wr_r |-> ##26 chip_enable_strobe ##1 !chip_enable_strobe;
    endproperty
    a_ce_rd: assert property (p_ce_rd) else $error("read chip enable fall wrong"); // RULE_10

    property p_ce_wr;
        s_ref and wr_r |-> ##31 chip_enable_strobe ##1 !chip_enable_strobe;
    endproperty
    a_ce_wr: assert property (p_ce_wr) else $error("write chip enable fall wrong"); // RULE_11

    property p_pend;
        rise[PIN_START] && (state_r == ST_RUN) && !last |=> pend_r;
    endproperty
    a_pend: assert property (p_pend) else $error("start during cycle lost"); // RULE_12

    property p_rw_on;
        s_ref and wr_r |-> ##14 !rw_strobe ##1 rw_strobe;
    endproperty
    a_rw_on: assert property (p_rw_on) else $error("rw strobe rise wrong"); // RULE_13

    property p_rw_off;
        $fell(chip_enable_strobe) && wr_r |-> rw_strobe [*8] ##1 !rw_strobe;
    endproperty
    a_rw_off: assert property (p_rw_off) else $error("rw strobe fall wrong"); // RULE_14

endmodule
`default_nettype wire

// *** src/cmst_pkg.sv ***
/*
 * Constants for the clock and memory strobe generator.
 * Assumes a 200 MHz system clock.
 */
`default_nettype none
package cmst_pkg;
    localparam int SYS_HZ  = 200_000_000;
    localparam int FAST_HZ = 8_000_000;
    localparam int CLK_NS  = 5;
    localparam logic [4:0] FAST_DIV  = 5'(SYS_HZ / FAST_HZ);
    localparam logic [4:0] FAST_HIGH = 5'((SYS_HZ / FAST_HZ + 1) / 2);
    // Strobe times in ns; rises counted from the half-rate falling edge, falls from the next half-rate edge or chip enable fall
    localparam int IO_DLY_NS   = 50;
    localparam int CE_ON_NS    = 25;
    localparam int RW_ON_NS    = 70;
    localparam int PC_ON_NS    = 90;
    localparam int HALF_NS     = 125;
    localparam int CE_RD_NS    = 5;
    localparam int CE_WR_NS    = 30;
    localparam int PC_TRAIL_NS = 30;
    localparam int RW_TRAIL_NS = 40;
    localparam int IO_DLY = (IO_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] CE_ON  = 6'((CE_ON_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] RW_ON  = 6'((RW_ON_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] PC_ON  = 6'((PC_ON_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] CE_RD  = 6'((HALF_NS + CE_RD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] CE_WR  = 6'((HALF_NS + CE_WR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] PC_TRL = 6'((PC_TRAIL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [5:0] RW_TRL = 6'((RW_TRAIL_NS + CLK_NS - 1) / CLK_NS);
    // Mains cycles per tick; both give a 10 Hz tick
    localparam logic [2:0] MAINS_DIV_60 = 3'h6;
    localparam logic [2:0] MAINS_DIV_50 = 3'h5;
    localparam logic [2:0] STRAP_SETTLE = 3'h5;
    // Synchronised pin indices
    localparam int PIN_N     = 4;
    localparam int PIN_START = 0;
    localparam int PIN_WR    = 1;
    localparam int PIN_MAINS = 2;
    localparam int PIN_J50   = 3;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} cmst_state_e;
endpackage
`default_nettype wire

// *** testbench/cmst_mem_model.sv ***
/*
 * Far-side model: memory array strobe receivers and the mains transformer.
 * Assumes every strobe and clock it watches is registered on clk rising edges.
 */
`default_nettype none
module cmst_mem_model
    import cmst_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       mains_en,
    input  wire logic       half_rate_clock_out,
    input  wire logic       chip_enable_strobe,
    input  wire logic       precharge_strobe,
    input  wire logic       rw_strobe,
    output var  logic       mains_transformer_in,
    output var  logic       done,
    output var  logic [5:0] ce_on,
    output var  logic [5:0] ce_off,
    output var  logic [5:0] pc_on,
    output var  logic [5:0] pc_off,
    output var  logic [5:0] rw_on,
    output var  logic [5:0] rw_off
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [6:0] j_r;
    logic [4:0] mains_cnt_r;
    logic       half_q_r;
    logic       ce_q_r;
    logic       pc_q_r;
    logic       rw_q_r;
    logic       busy_r;

    // Mains square wave, 60 clk per cycle so many ticks fit in a short run
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mains_transformer_in <= 1'b0;
            mains_cnt_r          <= 5'h0;
        end else if (!mains_en) begin
            mains_transformer_in <= 1'b0;
            mains_cnt_r          <= 5'h0;
        end else if (mains_cnt_r == 5'h1d) begin
            mains_transformer_in <= ~mains_transformer_in;
            mains_cnt_r          <= 5'h0;
        end else begin
            mains_cnt_r <= mains_cnt_r + 5'h1;
        end
    end

    // Edge positions counted from the half-rate falling edge
    always_ff @(posedge clk or negedge rst_b) begin
        logic [6:0] jn;
        if (!rst_b) begin
            {j_r, half_q_r, ce_q_r, pc_q_r, rw_q_r, busy_r, done} <= '0;
            {ce_on, ce_off, pc_on, pc_off, rw_on, rw_off} <= '0;
        end else begin
            jn = (half_q_r && !half_rate_clock_out) ? 7'h0 : j_r + 7'h1;
            j_r      <= jn;
            half_q_r <= half_rate_clock_out;
            ce_q_r   <= chip_enable_strobe;
            pc_q_r   <= precharge_strobe;
            rw_q_r   <= rw_strobe;
            done     <= 1'b0;
            if (chip_enable_strobe && !ce_q_r) begin
                ce_on  <= jn[5:0];
                busy_r <= 1'b1;
                rw_on  <= 6'h0;
                rw_off <= 6'h0;
            end
            if (!chip_enable_strobe && ce_q_r) ce_off <= jn[5:0];
            if (precharge_strobe && !pc_q_r) pc_on <= jn[5:0];
            if (!precharge_strobe && pc_q_r) pc_off <= jn[5:0];
            if (rw_strobe && !rw_q_r) rw_on <= jn[5:0];
            if (!rw_strobe && rw_q_r) rw_off <= jn[5:0];
            if (busy_r && jn == 7'd45) begin
                done   <= 1'b1;
                busy_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/clock_memory_strobe_timing_tb_top.sv ***
/*
 * Self-checking bench for the clock and memory strobe generator.
 * Assumes the far-side model reports each memory cycle 45 clk after its reference edge.
 */
`default_nettype none
module clock_memory_strobe_timing_tb_top
    import cmst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk, rst_b, mains_en, jumper, start, wr_flag, mains, done;
    logic       fast, half, half_n, io_clk, tick, ce, pc, rw;
    logic [5:0] ce_on, ce_off, pc_on, pc_off, rw_on, rw_off;
    logic       fast_q, half_q, mains_q, tick_q, chk_en;
    int         failures, tests_run, cyc, since, rises, ticks;
    bit         exp_wr[$];
    logic       hq[$];

    cmst_clock_gen uut (.clk(clk), .rst_b(rst_b), .mains_transformer_in(mains), .mains_50hz_jumper(jumper),
        .memory_cycle_start(start), .write_cycle_flag(wr_flag), .fast_clock_out(fast),
        .half_rate_clock_out(half), .half_rate_clock_inverted(half_n), .io_side_clock(io_clk),
        .mains_tick_out(tick), .chip_enable_strobe(ce), .precharge_strobe(pc), .rw_strobe(rw));

    cmst_mem_model mem (.clk(clk), .rst_b(rst_b), .mains_en(mains_en), .half_rate_clock_out(half),
        .chip_enable_strobe(ce), .precharge_strobe(pc), .rw_strobe(rw), .mains_transformer_in(mains),
        .done(done), .ce_on(ce_on), .ce_off(ce_off), .pc_on(pc_on), .pc_off(pc_off), .rw_on(rw_on),
        .rw_off(rw_off));

    always #2.5 clk = ~clk;

    task automatic check_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_num(input string what, input logic [6:0] exp, input logic [6:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic j50);
        chk_en = 1'b0;
        rst_b    <= 1'b0;
        mains_en <= 1'b0;
        jumper   <= j50;
        start    <= 1'b0;
        repeat (8) @(posedge clk);
        check_bit("reset fast", 1'b0, fast);
        check_bit("reset half", 1'b0, half);
        check_bit("reset half inverted", 1'b1, half_n);
        check_bit("reset io", 1'b0, io_clk);
        check_bit("reset tick", 1'b0, tick);
        rst_b <= 1'b1;
        repeat (30) @(posedge clk);
        mains_en <= 1'b1;
        chk_en = 1'b1;
    endtask

    // Flag turns to its inverse once released so a late sample is caught
    task automatic mem_cycle(input bit wr, input int gap);
        start   <= 1'b1;
        wr_flag <= wr;
        exp_wr.push_back(wr);
        repeat (8) @(posedge clk);
        start   <= 1'b0;
        wr_flag <= ~wr;
        repeat (gap) @(posedge clk);
    endtask

    // Second start of each pair lands while the first is armed or running, so it waits pending
    task automatic run_phase(input logic j50);
        logic [6:0] div;
        div = j50 ? 7'(MAINS_DIV_50) : 7'(MAINS_DIV_60);
        do_reset(j50);
        for (int n = 0; n < 12; n++) begin
            mem_cycle(1'($urandom_range(1, 0)), 12);
            mem_cycle(1'($urandom_range(1, 0)), 250 + $urandom_range(99, 0));
        end
        mains_en <= 1'b0;
        repeat (20) @(posedge clk);
        check_num("tick count", 7'(rises / int'(div)), 7'(ticks));
        check_num("cycles left", 7'h0, 7'(exp_wr.size()));
    endtask

    always @(negedge clk) begin
        cyc++;
        if (cyc > 40000) begin
            failures++;
            close_out();
        end
    end

    always @(negedge clk) begin
        if (!rst_b) begin
            rises = 0;
            ticks = 0;
        end
        if (mains && !mains_q) rises++;
        if (tick) ticks++;
        if (tick && tick_q) check_bit("tick width", 1'b0, tick);
        mains_q = mains;
        tick_q  = tick;
        if (!chk_en) begin
            hq.delete();
            since = -100;
        end else begin
            check_bit("half inverted", ~half, half_n);
            hq.push_back(half);
            if (hq.size() > 10) check_bit("io clock", hq.pop_front(), io_clk);
            if (fast && !fast_q) begin
                if (since > 0) check_num("fast period", 7'(FAST_DIV), 7'(since));
                check_bit("half toggle", ~half_q, half);
                since = 0;
            end
            if (!fast && fast_q && since > 0) check_num("fast high", 7'(FAST_HIGH), 7'(since));
            since++;
        end
        fast_q = fast;
        half_q = half;
    end

    always @(posedge clk) begin
        logic       wr;
        logic [5:0] off;
        if (done) begin
            if (exp_wr.size() == 0) begin
                check_bit("cycle queued", 1'b1, 1'b0);
            end else begin
                wr  = exp_wr.pop_front();
                off = wr ? CE_WR : CE_RD;
                check_num("ce on", {1'b0, CE_ON}, {1'b0, ce_on});
                check_num("ce off", {1'b0, off}, {1'b0, ce_off});
                check_num("pc on", {1'b0, PC_ON}, {1'b0, pc_on});
                check_num("pc off", {1'b0, off + PC_TRL}, {1'b0, pc_off});
                check_num("rw on", wr ? {1'b0, RW_ON} : 7'h0, {1'b0, rw_on});
                check_num("rw off", wr ? {1'b0, off + RW_TRL} : 7'h0, {1'b0, rw_off});
            end
        end
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        mains_en = 1'b0;
        jumper = 1'b0;
        start = 1'b0;
        wr_flag = 1'b0;
        {fast_q, half_q, mains_q, tick_q, chk_en} = '0;
        {failures, tests_run, cyc, rises, ticks} = '0;
        since = -100;
        void'($urandom(32'h8eb53fef));
        run_phase(1'b0);
        run_phase(1'b1);
        close_out();
    end
endmodule
`default_nettype wire
